/* File: hdl/vrefc_pkg.sv */
// constants and types for the voltage reference control register
// ------------------------------------------------------------
// ------------------------------------------------------------
`default_nettype none
package vrefc_pkg;
    localparam logic [7:0] VREFC_ADDR = 8'hD2;
    localparam logic [7:0] VREFC_PAGE = 8'h0F;
    localparam logic [7:0] VREFC_RESET = 8'h10;
    localparam logic [7:0] VREFC_WMASK = 8'h3E;
    localparam int VREFC_GND_BIT = 5;
    localparam int VREFC_SEL_LO = 3;
    localparam int VREFC_TEMP_BIT = 2;
    localparam int VREFC_BIAS_BIT = 1;
    localparam logic [1:0] VREFC_SEL_EXT = 2'h0;
    localparam logic [1:0] VREFC_SEL_VDD = 2'h1;
    localparam logic [1:0] VREFC_SEL_DIG = 2'h2;
    localparam logic [1:0] VREFC_SEL_HS = 2'h3;
    // one-hot reference mux selects: ext, vdd, digital, high-speed
    localparam logic [3:0] VREFC_OH_EXT = 4'h1;
    localparam logic [3:0] VREFC_OH_VDD = 4'h2;
    localparam logic [3:0] VREFC_OH_DIG = 4'h4;
    localparam logic [3:0] VREFC_OH_HS = 4'h8;

    typedef struct packed {
        logic [7:0] reg_r;
    } vrefc_state_t;

    typedef struct packed {
        logic [3:0] mux_sel_r;
        logic hs_ref_en_r;
        logic gnd_sel_r;
        logic temp_en_r;
        logic bias_en_r;
    } vrefc_out_t;
endpackage : vrefc_pkg
`default_nettype wire

/* File: hdl/vrefc_if.sv */
// control field carrier between register and analog decode
`default_nettype none
interface vrefc_if;
    import vrefc_pkg::*;
    logic [7:0] ctrl;
    logic conv_busy;
    modport regs (output ctrl, output conv_busy);
    modport dec (input ctrl, input conv_busy);
endinterface : vrefc_if
`default_nettype wire

/* File: hdl/vrefc_decode.sv */
// decode of stored register bits into analog selects and enables
`default_nettype none
module vrefc_decode
    import vrefc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register fields
    vrefc_if.dec fld,
    // analog controls
    output logic [3:0] vref_mux_sel,
    output logic hs_ref_enable,
    output logic ground_ref_select,
    output logic temp_sensor_enable,
    output logic analog_bias_enable
);
    vrefc_out_t st_r;
    vrefc_out_t st_nxt;

    // --------------------------------------------------------
    // next-state decode
    // --------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        case (fld.ctrl[VREFC_SEL_LO +: 2])
            VREFC_SEL_EXT: st_nxt.mux_sel_r = VREFC_OH_EXT;
            VREFC_SEL_VDD: st_nxt.mux_sel_r = VREFC_OH_VDD;
            VREFC_SEL_DIG: st_nxt.mux_sel_r = VREFC_OH_DIG;
            default: st_nxt.mux_sel_r = VREFC_OH_HS;
        endcase
        // reference powered only on demand
        st_nxt.hs_ref_en_r = (fld.ctrl[VREFC_SEL_LO +: 2] == VREFC_SEL_HS)
            && fld.conv_busy;
        st_nxt.gnd_sel_r = fld.ctrl[VREFC_GND_BIT];
        st_nxt.temp_en_r = fld.ctrl[VREFC_TEMP_BIT];
        st_nxt.bias_en_r = fld.ctrl[VREFC_BIAS_BIT];
        if (!resetn) begin
            st_nxt = '0;
            // reset byte selects the digital supply reference
            st_nxt.mux_sel_r = VREFC_OH_DIG;
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        st_r <= st_nxt;
    end

    // outputs straight from flops
    assign vref_mux_sel = st_r.mux_sel_r;
    assign hs_ref_enable = st_r.hs_ref_en_r;
    assign ground_ref_select = st_r.gnd_sel_r;
    assign temp_sensor_enable = st_r.temp_en_r;
    assign analog_bias_enable = st_r.bias_en_r;
endmodule : vrefc_decode
`default_nettype wire

/* File: hdl/vrefc_top.sv */
// voltage reference control register on the special-function bus
`default_nettype none
module vrefc_top
    import vrefc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // special-function register bus
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_sel,
    // converter status
    input wire logic conv_busy,
    // analog controls
    output logic [3:0] vref_mux_sel,
    output logic hs_ref_enable,
    output logic ground_ref_select,
    output logic temp_sensor_enable,
    output logic analog_bias_enable
);

    // --------------------------------------------------------
    // local types
    // --------------------------------------------------------
    // named view of the writable fields of the control byte
    typedef struct packed {
        // ground reference: pin or analog ground
        logic gnd_sel;
        // two-bit voltage reference choice
        logic [1:0] ref_sel;
        // temperature sensor power
        logic temp_en;
        // analog bias generator power
        logic bias_en;
    } vrefc_fields_t;

    // all registered state of the bus side
    typedef struct packed {
        // stored control byte, unused bits kept low
        logic [7:0] ctrl_r;
        // read answer, zero outside a read
        logic [7:0] rdata_r;
        // access select, one cycle per hit
        logic sel_r;
    } vrefc_top_t;

    // --------------------------------------------------------
    // helper functions
    // --------------------------------------------------------
    // address and page match for this register
    function automatic logic vrefc_match(
        input logic [7:0] addr,
        input logic [7:0] page
    );
        logic addr_ok;
        logic page_ok;
        // address and page compared separately
        addr_ok = (addr == VREFC_ADDR);
        page_ok = (page == VREFC_PAGE); // other pages hide the register
        return addr_ok && page_ok;
    endfunction

    // split a control byte into its writable fields
    function automatic vrefc_fields_t vrefc_unpack(
        input logic [7:0] val
    );
        vrefc_fields_t f;
        // one field per bit position
        f.gnd_sel = val[VREFC_GND_BIT];
        f.ref_sel = val[VREFC_SEL_LO +: 2];
        f.temp_en = val[VREFC_TEMP_BIT];
        f.bias_en = val[VREFC_BIAS_BIT];
        // bits 7, 6 and 0 are dropped here
        return f;
    endfunction

    // rebuild a control byte with the unused bits low
    function automatic logic [7:0] vrefc_pack(
        input vrefc_fields_t f
    );
        logic [7:0] val;
        val = '0;
        // each field back at its bit position
        val[VREFC_GND_BIT] = f.gnd_sel;
        val[VREFC_SEL_LO +: 2] = f.ref_sel;
        val[VREFC_TEMP_BIT] = f.temp_en;
        val[VREFC_BIAS_BIT] = f.bias_en;
        return val;
    endfunction

    // --------------------------------------------------------
    // state, strobes and field views
    // --------------------------------------------------------
    // registered bus-side state
    vrefc_top_t st_r;

    // next value from the update process
    vrefc_top_t st_nxt;

    // access qualifiers for this cycle
    logic hit;
    logic wr_hit;
    logic rd_hit;
    logic acc_hit;

    // field views of the stored byte and of the bus data
    vrefc_fields_t cur_fld;
    vrefc_fields_t wr_fld;

    // cleaned bytes for storage and read-back
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;

    // --------------------------------------------------------
    // interface carrier
    // --------------------------------------------------------
    // carrier towards the analog decode
    vrefc_if fld ();

    // --------------------------------------------------------
    // access qualification
    // --------------------------------------------------------
    // register selected by address and page
    assign hit = vrefc_match(sfr_addr, sfr_page);

    // write strobe that reaches this register
    assign wr_hit = hit && sfr_wr;

    // read strobe that reaches this register
    assign rd_hit = hit && sfr_rd;

    // either strobe that reaches this register
    assign acc_hit = wr_hit || rd_hit;

    // --------------------------------------------------------
    // write merge and read-back
    // --------------------------------------------------------
    // field views of bus data and of the stored byte
    assign wr_fld = vrefc_unpack(sfr_wdata);
    assign cur_fld = vrefc_unpack(st_r.ctrl_r);

    // unused bits can be neither stored nor read back set
    assign wr_byte = vrefc_pack(wr_fld);
    assign rd_byte = vrefc_pack(cur_fld);

    // --------------------------------------------------------
    // register update
    // --------------------------------------------------------
    // next state: write, read-back and select, reset last
    always_comb begin
        st_nxt = st_r;

        // select answers any access that hits
        st_nxt.sel_r = acc_hit;

        // a write stores only the writable fields
        if (wr_hit) begin
            st_nxt.ctrl_r = wr_byte;
        end

        // a read returns the byte held before this edge
        if (rd_hit) begin
            st_nxt.rdata_r = rd_byte;
        end else begin
            st_nxt.rdata_r = '0; // idle bus reads zero
        end

        // synchronous reset wins over any access
        if (!resetn) begin
            st_nxt.ctrl_r = VREFC_RESET;
            st_nxt.rdata_r = '0;
            st_nxt.sel_r = 1'b0;
        end
    end

    // --------------------------------------------------------
    // state register
    // --------------------------------------------------------
    // one flop bank for all bus-side state
    always_ff @(posedge mclk) begin
        st_r <= st_nxt;
    end

    // --------------------------------------------------------
    // analog decode
    // --------------------------------------------------------
    // fields to the decoder from stored bits
    assign fld.ctrl = st_r.ctrl_r;

    // converter demand passes straight through
    assign fld.conv_busy = conv_busy;

    // selects and enables registered in the decoder
    vrefc_decode u_dec (
        // clock and reset
        .mclk(mclk),
        .resetn(resetn),
        // register fields
        .fld(fld),
        // analog controls
        .vref_mux_sel(vref_mux_sel),
        .hs_ref_enable(hs_ref_enable),
        .ground_ref_select(ground_ref_select),
        .temp_sensor_enable(temp_sensor_enable),
        .analog_bias_enable(analog_bias_enable)
    );

    // --------------------------------------------------------
    // bus outputs
    // --------------------------------------------------------
    // read data and select straight from flops
    assign sfr_rdata = st_r.rdata_r;
    assign sfr_sel = st_r.sel_r;
endmodule : vrefc_top
`default_nettype wire

/* File: tb/vrefc_conv_model.sv */
// converter model that asks for the reference in random bursts
`default_nettype none
module vrefc_conv_model (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // reference request
    output logic conv_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // busy toggles at random, like conversions starting and ending
    always_ff @(posedge mclk) begin
        if (!resetn) conv_busy <= 1'b0;
        else if ($urandom % 4 == 0) conv_busy <= ~conv_busy;
    end
endmodule // vrefc_conv_model
`default_nettype wire

/* File: tb/vrefc_sva.sv */
// assertions on the voltage reference control register ports
`default_nettype none
module vrefc_sva
    import vrefc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // special-function register bus
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_sel,
    // converter status
    input wire logic conv_busy,
    // analog controls
    input wire logic [3:0] vref_mux_sel,
    input wire logic hs_ref_enable,
    input wire logic ground_ref_select,
    input wire logic temp_sensor_enable,
    input wire logic analog_bias_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hit, wh;
    // accesses that hit this register
    assign hit = sfr_addr == VREFC_ADDR && sfr_page == VREFC_PAGE && (sfr_wr || sfr_rd);
    assign wh = hit && sfr_wr;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_hit; hit |=> sfr_sel; endproperty
    a_hit: assert property (p_hit) else $error("no select after hit");
    property p_miss; !hit |=> !sfr_sel && sfr_rdata == 8'h00; endproperty
    a_miss: assert property (p_miss) else $error("answer without hit");
    property p_top; sfr_rdata[7:6] == 2'h0; endproperty
    a_top: assert property (p_top) else $error("upper bits read set");
    property p_b0; !sfr_rdata[0]; endproperty
    a_b0: assert property (p_b0) else $error("bit zero read set");
    property p_mux; wh |=> ##1 vref_mux_sel == 4'h1 << $past(sfr_wdata[4:3], 2); endproperty
    a_mux: assert property (p_mux) else $error("wrong reference select");
    property p_fld;
        wh |=> ##1 {ground_ref_select, temp_sensor_enable, analog_bias_enable}
            == {$past(sfr_wdata[5], 2), $past(sfr_wdata[2], 2), $past(sfr_wdata[1], 2)};
    endproperty
    a_fld: assert property (p_fld) else $error("wrong enables");
    property p_hs; hs_ref_enable == (vref_mux_sel == VREFC_OH_HS && $past(conv_busy)); endproperty
    a_hs: assert property (p_hs) else $error("wrong fast reference enable");
    property p_hold;
        $past(resetn) && !$past(wh, 2) |-> $stable({vref_mux_sel, ground_ref_select,
            temp_sensor_enable,
            analog_bias_enable});
    endproperty
    a_hold: assert property (p_hold) else $error("controls moved without write");
    // main scenarios
    c_wr: cover property (wh);
    c_rd: cover property (hit && sfr_rd);
    c_hs: cover property (hs_ref_enable);
endmodule // vrefc_sva
bind vrefc_top vrefc_sva vrefc_sva_i (.mclk(mclk), .resetn(resetn), .sfr_addr(sfr_addr),
    .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .sfr_sel(sfr_sel), .conv_busy(conv_busy),
    .vref_mux_sel(vref_mux_sel), .hs_ref_enable(hs_ref_enable),
    .ground_ref_select(ground_ref_select), .temp_sensor_enable(temp_sensor_enable),
    .analog_bias_enable(analog_bias_enable));
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the voltage reference control register
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import vrefc_pkg::*;
    logic mclk = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0, hit, e_sel, e_hs, conv_busy;
    logic [7:0] sfr_addr = 0, sfr_page = 0, sfr_wdata = 0, sfr_rdata, m, e_rd;
    logic sfr_sel, hs_ref_enable, ground_ref_select, temp_sensor_enable, analog_bias_enable;
    logic [3:0] vref_mux_sel, e_mux;
    logic [2:0] e_f;
    int fails = 0, num_checks = 0;
    always #4 mclk = ~mclk;
    vrefc_top vrefc_top_i (.mclk(mclk), .resetn(resetn), .sfr_addr(sfr_addr),
        .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_sel(sfr_sel), .conv_busy(conv_busy),
        .vref_mux_sel(vref_mux_sel), .hs_ref_enable(hs_ref_enable),
        .ground_ref_select(ground_ref_select), .temp_sensor_enable(temp_sensor_enable),
        .analog_bias_enable(analog_bias_enable));
    vrefc_conv_model vrefc_conv_model_i (.mclk(mclk), .resetn(resetn), .conv_busy(conv_busy));
    // compare bus answer and analog controls with the model
    task chk_bus();
        num_checks++;
        if (sfr_rdata !== e_rd || sfr_sel !== e_sel) begin
            fails++;
            $display("MISMATCH %0t bus answer", $time);
        end
    endtask
    task chk_ana();
        num_checks++;
        if ({vref_mux_sel, hs_ref_enable, ground_ref_select, temp_sensor_enable,
            analog_bias_enable} !== {e_mux, e_hs, e_f}) begin
            fails++;
            $display("MISMATCH %0t analog controls", $time);
        end
    endtask
    task give_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // random accesses, model register updated per edge
    initial begin
        void'($urandom(97));
        m = VREFC_RESET;
        {e_rd, e_sel, e_mux, e_hs, e_f} = {8'h00, 1'b0, VREFC_OH_DIG, 1'b0, 3'h0};
        repeat (4) @(negedge mclk);
        resetn = 1;
        for (int i = 0; i < 400; i++) begin
            @(negedge mclk);
            chk_bus();
            chk_ana();
            if (i == 0) $display("test reset done");
            if (i == 203) $display("test mid-run reset done");
            resetn = !(i == 200 || i == 201); // second reset, two edges mid-run
            sfr_addr = ($urandom % 4) ? VREFC_ADDR : 8'($urandom);
            sfr_page = ($urandom % 4) ? VREFC_PAGE : 8'($urandom);
            sfr_wr = 1'($urandom);
            sfr_rd = 1'($urandom);
            sfr_wdata = 8'($urandom);
            hit = sfr_addr == VREFC_ADDR && sfr_page == VREFC_PAGE;
            e_sel = hit && (sfr_wr || sfr_rd);
            e_rd = (hit && sfr_rd) ? m : 8'h00;
            e_mux = 4'h1 << m[4:3];
            e_hs = m[4:3] == 2'h3 && conv_busy;
            e_f = {m[5], m[2], m[1]};
            if (hit && sfr_wr) m = sfr_wdata & VREFC_WMASK;
            if (!resetn) begin
                m = VREFC_RESET; // reset wins over the access
                {e_rd, e_sel, e_mux, e_hs, e_f} = {8'h00, 1'b0, VREFC_OH_DIG, 1'b0, 3'h0};
            end
        end
        $display("test random done");
        give_verdict();
    end
    // watchdog
    initial begin
        #20000;
        fails++;
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
